// file: src/iotp_clock_ctrl.v
`timescale 1ns/1ps
`include "iotp_regs.vh"

module iotp_clock_ctrl (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Oscillator levels and straps
  input  wire        hf_osc_in,
  input  wire        mf_osc_in,
  input  wire        lf_osc_in,
  input  wire        multiplier_config_fuse,
  input  wire        internal_clock_mode,
  // Oscillator control outputs
  output reg  [5:0]  hf_trim_code,
  output reg  [5:0]  mf_trim_code,
  output reg         multiplier_enable,
  output reg         internal_clock_output,
  output reg         lf_timer_clock,
  output reg         lf_primary_clock
);

  // Input synchronisers
  wire [`IOTP_SYNC_W-1:0] sync_raw;
  reg  [`IOTP_SYNC_W-1:0] sync_a;
  reg  [`IOTP_SYNC_W-1:0] sync_b;
  reg  [2:0]              osc_prev;
  wire [2:0]              osc_edge;

  assign sync_raw = {internal_clock_mode, multiplier_config_fuse,
                     lf_osc_in, mf_osc_in, hf_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < `IOTP_SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= sync_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire hf_level  = sync_b[0];
  wire mf_level  = sync_b[1];
  wire lf_level  = sync_b[2];
  wire fuse_lvl  = sync_b[3];
  wire int_mode  = sync_b[4];

  // Both edges count, so each edge marks one oscillator half period
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev <= 3'h0;
    end else begin
      osc_prev <= sync_b[2:0];
    end
  end
  assign osc_edge = sync_b[2:0] ^ osc_prev;

  // Registers
  reg [`IOTP_TUNE_MSB:0] tune;
  reg [`IOTP_FSEL_MSB:0] fsel;
  reg                    route_mid;

  // Bus data phase state
  reg                    wr_pend;
  reg [`IOTP_ADDR_MSB:0] wr_addr;
  wire addr_phase = hsel & htrans[1] & hready;

  // Write applied this cycle, used for both update and read forwarding
  reg [`IOTP_TUNE_MSB:0] next_tune;
  reg [`IOTP_FSEL_MSB:0] next_fsel;
  reg                    next_route_mid;
  always @* begin
    next_tune      = tune;
    next_fsel      = fsel;
    next_route_mid = route_mid;
    if (wr_pend) begin
      case (wr_addr)
        `IOTP_ADDR_TUNE: begin
          next_tune = hwdata[`IOTP_TUNE_MSB:0];
        end
        `IOTP_ADDR_CTRL: begin
          next_fsel = hwdata[`IOTP_FSEL_MSB:0];
        end
        `IOTP_ADDR_CTRL2: begin
          next_route_mid = hwdata[`IOTP_ROUTE_BIT];
        end
        default: begin
          next_tune = tune;
        end
      endcase
    end
  end

  // Multiplier enable, fuse ignored in internal clock modes
  reg next_mult;
  always @* begin
    if (int_mode) begin
      next_mult = next_tune[`IOTP_TUNE_MULT_BIT];
    end else begin
      next_mult = next_tune[`IOTP_TUNE_MULT_BIT] | fuse_lvl;
    end
  end

  // Source and ratio selection
  reg [1:0]             sel_src;
  reg [`IOTP_DIV_MSB:0] sel_ratio;
  always @* begin
    sel_src   = `IOTP_SRC_HF;
    sel_ratio = `IOTP_DIV_1;
    case (fsel)
      `IOTP_FSEL_16M: begin
        sel_ratio = `IOTP_DIV_1;
      end
      `IOTP_FSEL_8M: begin
        sel_ratio = `IOTP_DIV_2;
      end
      `IOTP_FSEL_4M: begin
        sel_ratio = `IOTP_DIV_4;
      end
      `IOTP_FSEL_2M: begin
        sel_ratio = `IOTP_DIV_8;
      end
      `IOTP_FSEL_1M: begin
        sel_ratio = `IOTP_DIV_16;
      end
      `IOTP_FSEL_500K: begin
        sel_src   = route_mid ? `IOTP_SRC_MF : `IOTP_SRC_HF;
        sel_ratio = route_mid ? `IOTP_DIV_1 : `IOTP_DIV_32;
      end
      `IOTP_FSEL_250K: begin
        sel_src   = route_mid ? `IOTP_SRC_MF : `IOTP_SRC_HF;
        sel_ratio = route_mid ? `IOTP_DIV_2 : `IOTP_DIV_64;
      end
      `IOTP_FSEL_31K: begin
        if (!tune[`IOTP_TUNE_SRC_BIT]) begin
          sel_src   = `IOTP_SRC_LF;
          sel_ratio = `IOTP_DIV_1;
        end else begin
          sel_src   = route_mid ? `IOTP_SRC_MF : `IOTP_SRC_HF;
          sel_ratio = route_mid ? `IOTP_DIV_16 : `IOTP_DIV_512;
        end
      end
      default: begin
        sel_ratio = `IOTP_DIV_1;
      end
    endcase
  end

  reg sel_edge;
  always @* begin
    case (sel_src)
      `IOTP_SRC_LF: begin
        sel_edge = osc_edge[2];
      end
      `IOTP_SRC_MF: begin
        sel_edge = osc_edge[1];
      end
      default: begin
        sel_edge = osc_edge[0];
      end
    endcase
  end

  // Restart the divider on any change so no runt count carries over
  reg [1:0]             prev_src;
  reg [`IOTP_DIV_MSB:0] prev_ratio;
  wire div_restart = (prev_src != sel_src) | (prev_ratio != sel_ratio);
  wire div_clk;

  iotp_divider u_divider (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .src_edge (sel_edge),
    .ratio    (sel_ratio),
    .restart  (div_restart),
    .clk_out  (div_clk)
  );

  // Read mux, tune and control fed from post-write values so back-to-back reads are fresh; status reads registered state
  reg [31:0] rd_value;
  always @* begin
    rd_value = 32'h0000_0000;
    case (haddr[`IOTP_ADDR_MSB:0])
      `IOTP_ADDR_TUNE: begin
        rd_value[`IOTP_TUNE_MSB:0] = next_tune;
      end
      `IOTP_ADDR_CTRL: begin
        rd_value[`IOTP_FSEL_MSB:0] = next_fsel;
      end
      `IOTP_ADDR_CTRL2: begin
        rd_value[`IOTP_ROUTE_BIT] = next_route_mid;
      end
      `IOTP_ADDR_STAT: begin
        rd_value[`IOTP_STAT_MULT_BIT] = multiplier_enable;
        rd_value[`IOTP_STAT_MODE_BIT] = int_mode;
        rd_value[`IOTP_STAT_SRC_MSB:`IOTP_STAT_SRC_LSB] = sel_src;
        rd_value[`IOTP_STAT_FACT_MSB:`IOTP_STAT_FACT_LSB] =
          `IOTP_MULT_FACTOR;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // Bus and register state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      wr_pend    <= 1'b0;
      wr_addr    <= `IOTP_ADDR_TUNE;
      tune       <= `IOTP_TUNE_RESET;
      fsel       <= `IOTP_FSEL_RESET;
      route_mid  <= 1'b0;
      prev_src   <= `IOTP_SRC_HF;
      prev_ratio <= `IOTP_DIV_16;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      // Sub-word writes are dropped rather than merged
      wr_pend    <= addr_phase & hwrite & (hsize == `IOTP_HSIZE_WORD);
      if (addr_phase) begin
        wr_addr <= haddr[`IOTP_ADDR_MSB:0];
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= rd_value;
      end
      tune       <= next_tune;
      fsel       <= next_fsel;
      route_mid  <= next_route_mid;
      prev_src   <= sel_src;
      prev_ratio <= sel_ratio;
    end
  end

  // Oscillator side outputs
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hf_trim_code          <= 6'h00;
      mf_trim_code          <= 6'h00;
      multiplier_enable     <= 1'b0;
      internal_clock_output <= 1'b0;
      lf_timer_clock        <= 1'b0;
      lf_primary_clock      <= 1'b0;
    end else begin
      // Trim passed straight on, oscillators settle with no busy flag
      hf_trim_code <= tune[`IOTP_TUNE_TRIM_MSB:0];
      mf_trim_code <= tune[`IOTP_TUNE_TRIM_MSB:0];
      multiplier_enable     <= next_mult;
      internal_clock_output <= div_clk;
      // Low osc path has no trim input at all
      lf_timer_clock   <= lf_level;
      lf_primary_clock <= lf_level;
    end
  end

endmodule // iotp_clock_ctrl

// file: src/iotp_regs.vh
`ifndef IOTP_REGS_VH
`define IOTP_REGS_VH

// Register byte offsets
`define IOTP_ADDR_TUNE      12'h000
`define IOTP_ADDR_CTRL      12'h004
`define IOTP_ADDR_CTRL2     12'h008
`define IOTP_ADDR_STAT      12'h00C
`define IOTP_ADDR_MSB       11

// Tuning register fields
`define IOTP_TUNE_SRC_BIT   7
`define IOTP_TUNE_MULT_BIT  6
`define IOTP_TUNE_TRIM_MSB  5
`define IOTP_TUNE_RESET     8'h00
`define IOTP_TUNE_MSB       7

// Control register fields
`define IOTP_FSEL_MSB       2
`define IOTP_ROUTE_BIT      0

// Frequency select codes
`define IOTP_FSEL_16M       3'h7
`define IOTP_FSEL_8M        3'h6
`define IOTP_FSEL_4M        3'h5
`define IOTP_FSEL_2M        3'h4
`define IOTP_FSEL_1M        3'h3
`define IOTP_FSEL_500K      3'h2
`define IOTP_FSEL_250K      3'h1
`define IOTP_FSEL_31K       3'h0
`define IOTP_FSEL_RESET     `IOTP_FSEL_1M

// Clock source codes
`define IOTP_SRC_LF         2'h0
`define IOTP_SRC_MF         2'h1
`define IOTP_SRC_HF         2'h2

// Divide ratios, as half-period edge count minus one
`define IOTP_DIV_1          9'h000
`define IOTP_DIV_2          9'h001
`define IOTP_DIV_4          9'h003
`define IOTP_DIV_8          9'h007
`define IOTP_DIV_16         9'h00F
`define IOTP_DIV_32         9'h01F
`define IOTP_DIV_64         9'h03F
`define IOTP_DIV_512        9'h1FF
`define IOTP_DIV_MSB        8

// Status register fields
`define IOTP_STAT_MULT_BIT  0
`define IOTP_STAT_MODE_BIT  1
`define IOTP_STAT_SRC_LSB   2
`define IOTP_STAT_SRC_MSB   3
`define IOTP_STAT_FACT_LSB  4
`define IOTP_STAT_FACT_MSB  6
`define IOTP_MULT_FACTOR    3'h4

// Bus and synchroniser constants
`define IOTP_HSIZE_WORD     3'h2
`define IOTP_SYNC_W         5

`endif

// file: src/iotp_divider.v
`timescale 1ns/1ps
`include "iotp_regs.vh"

module iotp_divider (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    rst_n,
  // Source edges and ratio
  input  wire                    src_edge,
  input  wire [`IOTP_DIV_MSB:0]  ratio,
  input  wire                    restart,
  // Divided clock
  output reg                     clk_out
);

  reg [`IOTP_DIV_MSB:0] count;

  // Each source edge is one half period; ratio zero follows the source
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= `IOTP_DIV_1;
      clk_out <= 1'b0;
    end else if (restart) begin
      count <= `IOTP_DIV_1;
    end else if (src_edge) begin
      if (count == ratio) begin
        count   <= `IOTP_DIV_1;
        clk_out <= ~clk_out;
      end else begin
        count <= count + `IOTP_DIV_2;
      end
    end
  end

endmodule // iotp_divider

// file: sim/iotp_clock_ctrl_props.sv
`timescale 1ns/1ps
module iotp_props (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // Straps and oscillator controls
  input wire        multiplier_config_fuse,
  input wire        internal_clock_mode,
  input wire [5:0]  hf_trim_code,
  input wire [5:0]  mf_trim_code,
  input wire        multiplier_enable,
  input wire        lf_timer_clock,
  input wire        lf_primary_clock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire tk = hsel && htrans[1] && hready;
  wire wt = tk && hwrite && hsize == 3'h2 && haddr[11:0] == 12'h000;
  wire rd = tk && !hwrite;
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus wait or error seen");
  property p_rst; !$past(rst_n) |-> hf_trim_code == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("trim not zero after reset");
  property p_same; hf_trim_code == mf_trim_code; endproperty
  a_same: assert property (p_same) else $error("trim codes differ");
  property p_lf; lf_timer_clock == lf_primary_clock; endproperty
  a_lf: assert property (p_lf) else $error("slow clock copies differ");
  property p_trim; wt |=> ##2 hf_trim_code == $past(hwdata[5:0], 2); endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_mult;
    wt ##1 (multiplier_config_fuse == $past(multiplier_config_fuse, 5) &&
            internal_clock_mode == $past(internal_clock_mode, 5))
      |=> multiplier_enable == ($past(hwdata[6]) |
      ($past(multiplier_config_fuse) & ~$past(internal_clock_mode)));
  endproperty
  a_mult: assert property (p_mult) else $error("bad multiplier enable");
  property p_unmap; rd && haddr[11:0] > 12'h00C |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stat; rd && haddr[11:0] == 12'h00C |=> hrdata[6:4] == 3'h4; endproperty
  a_stat: assert property (p_stat) else $error("bad multiply factor");
  c_wr: cover property (wt);
  c_unmap: cover property (rd && haddr[11:0] > 12'h00C);
  c_mult: cover property ($rose(multiplier_enable));
endmodule // iotp_props

bind iotp_clock_ctrl iotp_props i_props (.*);

// file: sim/iotp_testbench.sv
`timescale 1ns/1ps
`include "iotp_regs.vh"
module testbench;
  reg         sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, fuse = 1, mode = 1;
  reg  [31:0] haddr = 0, hwdata = 0, d;
  reg  [1:0]  htrans = 0;
  reg  [2:0]  hsize = 3'h2;
  reg  [7:0]  cnt = 0;
  reg  [7:0]  tv [0:2];
  wire        hready, hresp, me, ico, lft, p, q;
  wire [31:0] hrdata;
  wire [5:0]  hft, mft;
  integer     err_total = 0, samples_checked = 0, i, n, m;
  iotp_clock_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .hf_osc_in(cnt[2]), .mf_osc_in(cnt[3]),
    .lf_osc_in(cnt[5]), .multiplier_config_fuse(fuse),
    .internal_clock_mode(mode), .hf_trim_code(hft), .mf_trim_code(mft),
    .multiplier_enable(me), .internal_clock_output(ico),
    .lf_timer_clock(lft), .lf_primary_clock(p));
  initial forever #50 sys_clk = ~sys_clk;
  // Oscillator levels: high every 4, mid every 8, low every 32 cycles
  always @(posedge sys_clk) cnt <= cnt + 8'h01;
  task results;
    begin
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [8*5-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input [11:0] a, input w, input [31:0] v);
    begin
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      d = hrdata;
    end
  endtask
  // Counts toggles; edge phase makes one toggle of slack unavoidable
  task meas(input integer e);
    reg pi, pl;
    begin
      repeat (8) @(posedge sys_clk);
      n = 0;
      m = 0;
      pi = ico;
      pl = lft;
      repeat (256) begin
        @(posedge sys_clk);
        #1;
        if (ico !== pi) n = n + 1;
        if (lft !== pl) m = m + 1;
        pi = ico;
        pl = lft;
      end
      chk("clkop", e, (n >= e - 1 && n <= e + 1) ? e : n);
      chk("lfclk", 8, (m >= 7 && m <= 9) ? 8 : m);
      chk("lfprm", {31'h0, lft}, {31'h0, p});
    end
  endtask
  initial begin
    tv[0] = 8'h5F;
    tv[1] = 8'hA0;
    tv[2] = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(`IOTP_ADDR_TUNE, 0, 0);
    chk("tune0", 0, d);
    bus(`IOTP_ADDR_CTRL, 0, 0);
    chk("fsel0", 3, d[2:0]);
    bus(`IOTP_ADDR_STAT, 0, 0);
    chk("fact", 4, d[6:4]);
    bus(12'h010, 0, 0);
    chk("unmap", 0, d);
    for (i = 0; i < 3; i = i + 1) begin
      bus(`IOTP_ADDR_TUNE, 1, {24'h0, tv[i]});
      bus(`IOTP_ADDR_TUNE, 0, 0);
      chk("tuneb", tv[i], d);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("hftr", tv[i][5:0], hft);
      chk("mftr", tv[i][5:0], mft);
      chk("mult", tv[i][6], me);
      @(posedge sys_clk);
    end
    // External mode: the fuse alone turns the multiplier on
    mode <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("fuse1", 1, me);
    fuse <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("fuse0", 0, me);
    mode <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      bus(`IOTP_ADDR_CTRL, 1, 7 - i);
      meas(64 >> i);
    end
    // Trim 0x1F must not disturb the low oscillator path
    bus(`IOTP_ADDR_TUNE, 1, 32'h1F);
    bus(`IOTP_ADDR_CTRL, 1, 0);
    meas(8);
    results;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total = err_total + 1;
    results;
  end
endmodule // testbench
